// ---- core/can_mob_status_timer_regs.v ----
// Operation
// - Read-only 16-bit bus timer, resets to zero
// - Read-only 16-bit trigger capture, resets zero
// - Read-only 8-bit fault counters, reset zero
// - Top field shows highest-priority pending object
// - Top field reads all ones when none
// - Low four priority bits are software storage
// - Page upper bits select object zero to five
// - Page bit three low enables index stepping
// - Page low bits index object data byte
// - Object storage not initialised by reset
// - Length mismatch flags warning, length always overwritten
// - Transmit done at EOF end; lowest first
// - Receive done after sixth EOF bit
// - Multiple matches update the lowest object only
// - Bit fault while sending, two exceptions
// - Stuff fault on six equal bits
// - CRC over destuffed frame, mismatch flags fault
// - Form fault on delimiters or EOF
// - Ack fault when sending and ack slot recessive
// - Two-bit operation field selects object mode
// - Operation kept; rewrite re-enables, unlocks clear
// - Timer ticks every eight times prescale-plus-one
// - Completion clears object enable status
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "can_mob_defs.vh"

module can_mob_status_timer_regs (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Controller links
  input wire controller_enable,
  input wire [5:0] irq_enable,
  output reg [5:0] object_in_use,
  output reg [5:0] object_irq_status,
  // Bit engine
  input wire bit_tick,
  input wire rx_bit,
  input wire tx_bit,
  input wire transmitting,
  input wire [3:0] frame_field,
  // Received frame
  input wire [5:0] rx_match,
  input wire [3:0] rx_length,
  input wire [63:0] rx_data,
  // Transmit request
  output reg tx_request,
  output reg [2:0] tx_select,
  output reg [3:0] tx_length
);

  // ****************************************
  // Storage
  // ****************************************
  // No reset on object storage: contents are undefined until written
  reg [7:0] stat_mem [0:5];
  reg [7:0] ctrl_mem [0:5];
  reg [7:0] data_mem [0:47];

  reg [15:0] timer_r;
  reg [10:0] div_cnt_r;
  reg [15:0] capture_r;
  reg [7:0] tx_fault_count;
  reg [7:0] rx_fault_count;
  reg [7:0] top_r;
  reg [7:0] page_r;
  reg [7:0] prescale_r;
  reg [5:0] lock_r;
  reg [5:0] stat_valid_r;
  reg [2:0] run_cnt_r;
  reg last_bit_r;
  reg [14:0] crc_r;
  reg [14:0] crc_rx_r;
  reg [2:0] eof_cnt_r;

  integer i;
  integer j;
  integer c;
  integer m;

  function [3:0] lowest;
    input [5:0] v;
    integer k;
    begin
      lowest = `NO_OBJECT;
      for (k = 5; k >= 0; k = k - 1) begin
        if (v[k]) begin
          lowest = k[3:0];
        end
      end
    end
  endfunction

  // ****************************************
  // Object selection
  // ****************************************
  reg [5:0] tx_cand;
  reg [5:0] rx_cand;
  reg [5:0] flags_any;
  always @* begin
    for (c = 0; c < 6; c = c + 1) begin
      tx_cand[c] = object_in_use[c] &&
                   ctrl_mem[c][7:6] == `OP_TRANSMIT;
      rx_cand[c] = object_in_use[c] && rx_match[c] &&
                   ctrl_mem[c][7];
      flags_any[c] = stat_valid_r[c] && (|stat_mem[c]);
    end
  end

  wire [3:0] tx_obj = lowest(tx_cand);
  wire [3:0] rx_obj = lowest(rx_cand);

  // ****************************************
  // Bit level checks
  // ****************************************
  wire f_sof = frame_field == `FLD_SOF;
  wire f_arb = frame_field == `FLD_ARB;
  wire f_ctrl = frame_field == `FLD_CTRL;
  wire f_crc = frame_field == `FLD_CRC;
  wire f_ack = frame_field == `FLD_ACK;
  wire f_eof = frame_field == `FLD_EOF;
  wire stuff_zone = f_sof | f_arb | f_ctrl | f_crc;
  wire run_full = run_cnt_r == `STUFF_RUN && !f_sof;
  wire stuff_bit = stuff_zone && run_full && rx_bit != last_bit_r;
  wire stuff_err = bit_tick && stuff_zone && run_full &&
                   rx_bit == last_bit_r;
  wire data_bit = bit_tick && stuff_zone && !stuff_bit && !stuff_err;
  wire crc_err = bit_tick && frame_field == `FLD_CRC_DEL &&
                 crc_rx_r != crc_r;
  wire form_err = bit_tick && !rx_bit &&
                  (frame_field == `FLD_CRC_DEL ||
                   frame_field == `FLD_ACK_DEL || f_eof);
  wire ack_err = bit_tick && f_ack && transmitting && rx_bit;
  // Lost arbitration and a dominant ack slot are not bit faults
  wire bit_err = bit_tick && transmitting && rx_bit != tx_bit &&
                 !(f_arb && tx_bit && !rx_bit) &&
                 !(f_ack && !rx_bit);
  wire tx_done_evt = bit_tick && f_eof && transmitting &&
                     eof_cnt_r == `EOF_TX_BIT;
  wire rx_done_evt = bit_tick && f_eof && !transmitting &&
                     eof_cnt_r == `EOF_RX_BIT && rx_obj != `NO_OBJECT;
  wire any_err = stuff_err | crc_err | form_err | ack_err | bit_err;
  wire tx_err_evt = any_err && transmitting;
  wire rx_err_evt = any_err && !transmitting;

  wire [3:0] ev_obj = transmitting ? tx_obj : rx_obj;
  wire ev_ok = ev_obj != `NO_OBJECT;
  wire len_warn = rx_done_evt &&
                  rx_length != ctrl_mem[rx_obj[2:0]][3:0];
  wire [7:0] set_vec = {len_warn, tx_done_evt, rx_done_evt,
                        bit_err, stuff_err, crc_err, form_err, ack_err};

  wire [14:0] crc_shift = {crc_r[13:0], 1'b0};
  wire [14:0] crc_nxt = (rx_bit ^ crc_r[14]) ? crc_shift ^ `CRC_POLY
                                             : crc_shift;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_cnt_r <= 3'h0;
      last_bit_r <= 1'b1;
      crc_r <= 15'h0000;
      crc_rx_r <= 15'h0000;
      eof_cnt_r <= 3'h0;
    end else if (bit_tick) begin
      if (!stuff_zone) begin
        run_cnt_r <= 3'h0;
      end else if (f_sof || rx_bit != last_bit_r || stuff_err) begin
        run_cnt_r <= 3'h1;
      end else begin
        run_cnt_r <= run_cnt_r + 3'h1;
      end
      last_bit_r <= rx_bit;
      // Restart at each start of frame: the engine may not tick when idle
      if (frame_field == `FLD_IDLE || f_sof) begin
        crc_r <= 15'h0000;
      end else if (data_bit && !f_crc) begin
        crc_r <= crc_nxt;
      end
      if (data_bit && f_crc) begin
        crc_rx_r <= {crc_rx_r[13:0], rx_bit};
      end
      eof_cnt_r <= f_eof ? eof_cnt_r + 3'h1 : 3'h0;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  wire access = psel && penable;
  wire done = access && pready;
  wire [2:0] sel = page_r[6:4];
  wire sel_ok = page_r[7:4] < `NUM_OBJECTS;
  wire [5:0] data_idx = {page_r[6:4], page_r[2:0]};
  reg [7:0] rd_val;
  reg hit;
  always @* begin
    hit = 1'b1;
    rd_val = 8'h00;
    case (paddr)
      `A_TIMER_LO: rd_val = timer_r[7:0];
      `A_TIMER_HI: rd_val = timer_r[15:8];
      `A_CAPTURE_LO: rd_val = capture_r[7:0];
      `A_CAPTURE_HI: rd_val = capture_r[15:8];
      `A_TX_FAULT: rd_val = tx_fault_count;
      `A_RX_FAULT: rd_val = rx_fault_count;
      `A_TOP_OBJ: rd_val = top_r;
      `A_PAGE: rd_val = page_r;
      `A_STATUS: rd_val = sel_ok ? stat_mem[sel] : 8'h00;
      `A_CONTROL: rd_val = sel_ok ? ctrl_mem[sel] : 8'h00;
      `A_DATA: rd_val = sel_ok ? data_mem[data_idx] : 8'h00;
      `A_PRESCALE: rd_val = prescale_r;
      default: hit = 1'b0;
    endcase
  end

  wire wr = done && pwrite && !pslverr;
  wire wr_stat = wr && paddr == `A_STATUS && sel_ok;
  wire wr_ctrl = wr && paddr == `A_CONTROL && sel_ok;
  wire wr_data = wr && paddr == `A_DATA && sel_ok;
  wire data_acc = done && !pslverr && paddr == `A_DATA;

  // One wait state: pready rises in the second access cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (access && !pready) begin
      pready <= 1'b1;
      pslverr <= !hit;
      prdata <= {24'h000000, rd_val};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ****************************************
  // Page, top object and prescale
  // ****************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_r <= 8'h00;
      top_r <= `TOP_OBJ_RESET;
      prescale_r <= 8'h00;
    end else begin
      if (wr && paddr == `A_PAGE) begin
        page_r <= pwdata[7:0];
      end else if (data_acc && !page_r[`STEP_N_BIT]) begin
        page_r[2:0] <= page_r[2:0] + 3'h1;
      end
      top_r[7:4] <= lowest(object_irq_status);
      if (wr && paddr == `A_TOP_OBJ) begin
        top_r[3:0] <= pwdata[3:0];
      end
      if (wr && paddr == `A_PRESCALE) begin
        prescale_r <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // Bus timer, capture and fault counters
  // ****************************************
  wire [10:0] div_limit = {prescale_r, `TIMER_PRE_LOG};
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_r <= 11'h000;
      timer_r <= 16'h0000;
      capture_r <= 16'h0000;
      tx_fault_count <= 8'h00;
      rx_fault_count <= 8'h00;
    end else begin
      if (!controller_enable) begin
        div_cnt_r <= 11'h000;
      end else if (div_cnt_r == div_limit) begin
        div_cnt_r <= 11'h000;
        timer_r <= timer_r + 16'h0001;
      end else begin
        div_cnt_r <= div_cnt_r + 11'h001;
      end
      if (bit_tick && f_sof) begin
        capture_r <= timer_r;
      end
      if (tx_err_evt) begin
        tx_fault_count <= (tx_fault_count > `FAULT_MAX - `TX_FAULT_STEP)
          ? `FAULT_MAX : tx_fault_count + `TX_FAULT_STEP;
      end else if (tx_done_evt && tx_fault_count != 8'h00) begin
        tx_fault_count <= tx_fault_count - 8'h01;
      end
      if (rx_err_evt && rx_fault_count != `FAULT_MAX) begin
        rx_fault_count <= rx_fault_count + 8'h01;
      end else if (rx_done_evt && rx_fault_count != 8'h00) begin
        rx_fault_count <= rx_fault_count - 8'h01;
      end
    end
  end

  // ****************************************
  // Object enable, lock and request outputs
  // ****************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      object_in_use <= 6'h00;
      object_irq_status <= 6'h00;
      lock_r <= 6'h00;
      stat_valid_r <= 6'h00;
      tx_request <= 1'b0;
      tx_select <= 3'h0;
      tx_length <= 4'h0;
    end else begin
      for (i = 0; i < 6; i = i + 1) begin
        if ((tx_done_evt || rx_done_evt) && ev_obj == i) begin
          object_in_use[i] <= 1'b0;
          lock_r[i] <= 1'b1;
        end
        if (wr_ctrl && sel == i) begin
          object_in_use[i] <= pwdata[7:6] != `OP_DISABLED;
          lock_r[i] <= 1'b0;
        end
        if (wr_stat && sel == i) begin
          stat_valid_r[i] <= 1'b1;
        end
      end
      object_irq_status <= irq_enable & flags_any;
      tx_request <= tx_obj != `NO_OBJECT;
      tx_select <= tx_obj[2:0];
      tx_length <= (tx_obj != `NO_OBJECT) ? ctrl_mem[tx_obj[2:0]][3:0]
                                          : 4'h0;
    end
  end

  // ****************************************
  // Object storage updates
  // ****************************************
  // Done flags cannot be cleared until the operation is rewritten
  wire [7:0] keep_mask = lock_r[sel] ? 8'h60 : 8'h00;
  wire [7:0] stat_wval = (pwdata[7:0] & ~keep_mask) |
                         (stat_mem[sel] & keep_mask);
  always @(posedge clk) begin
    for (m = 0; m < 6; m = m + 1) begin
      // A hardware set in the clearing cycle is never lost
      if ((wr_stat && sel == m) || (ev_ok && ev_obj == m)) begin
        stat_mem[m] <= ((wr_stat && sel == m) ? stat_wval : stat_mem[m])
          | ((ev_ok && ev_obj == m) ? set_vec : 8'h00);
      end
      if (wr_ctrl && sel == m) begin
        ctrl_mem[m] <= pwdata[7:0];
      end
      if (rx_done_evt && rx_obj == m) begin
        ctrl_mem[m][3:0] <= rx_length;
        for (j = 0; j < 8; j = j + 1) begin
          data_mem[m * 8 + j] <= rx_data[j * 8 +: 8];
        end
      end
    end
    if (wr_data && !(rx_done_evt && rx_obj[2:0] == sel)) begin
      data_mem[data_idx] <= pwdata[7:0];
    end
  end

endmodule

// ---- include/can_mob_defs.vh ----
`ifndef CAN_MOB_DEFS_VH
`define CAN_MOB_DEFS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define A_TIMER_LO    8'h00
`define A_TIMER_HI    8'h04
`define A_CAPTURE_LO  8'h08
`define A_CAPTURE_HI  8'h0c
`define A_TX_FAULT    8'h10
`define A_RX_FAULT    8'h14
`define A_TOP_OBJ     8'h18
`define A_PAGE        8'h1c
`define A_STATUS      8'h20
`define A_CONTROL     8'h24
`define A_DATA        8'h28
`define A_PRESCALE    8'h2c

// ****************************************
// Fields and reset values
// ****************************************
`define NUM_OBJECTS     4'h6
`define NO_OBJECT       4'hf
`define TOP_OBJ_RESET   8'hf0
`define STEP_N_BIT      3
`define LEN_WARN_BIT    7
`define TX_DONE_BIT     6
`define RX_DONE_BIT     5
`define OP_DISABLED     2'b00
`define OP_TRANSMIT     2'b01
`define OP_RECEIVE      2'b10
`define OP_FRAME_BUF    2'b11

// ****************************************
// Frame field codes from the bit engine
// ****************************************
`define FLD_IDLE     4'h0
`define FLD_SOF      4'h1
`define FLD_ARB      4'h2
`define FLD_CTRL     4'h3
`define FLD_CRC      4'h4
`define FLD_CRC_DEL  4'h5
`define FLD_ACK      4'h6
`define FLD_ACK_DEL  4'h7
`define FLD_EOF      4'h8

// ****************************************
// Protocol constants
// ****************************************
`define CRC_POLY      15'h4599
`define STUFF_RUN     3'h5
`define EOF_RX_BIT    3'h5
`define EOF_TX_BIT    3'h6
`define TX_FAULT_STEP 8'h08
`define FAULT_MAX     8'hff
`define TIMER_PRE_LOG 3'h7

`endif

// ---- test/can_regs_chk_sva.sv ----
`timescale 1ns/1ns
`include "can_mob_defs.vh"
module can_regs_chk (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Objects
  input wire [5:0] irq_enable,
  input wire [5:0] object_in_use,
  input wire [5:0] object_irq_status,
  input wire bit_tick,
  input wire [3:0] frame_field,
  input wire tx_request,
  input wire [2:0] tx_select
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ****
  // Helpers
  // ****
  // Position inside the end-of-frame field, before this tick
  reg [2:0] eof_n;
  wire done = psel && penable && pready;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      eof_n <= 3'h0;
    else if (bit_tick)
      eof_n <= (frame_field == `FLD_EOF) ? eof_n + 3'h1 : 3'h0;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  // ****
  // Properties
  // ****
  a_ready_wait: assert property (
    s_setup ##1 s_wait |=> pready) else $error("no answer after wait");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("pready longer than one cycle");
  a_unmapped_err: assert property (
    done && paddr > `A_PRESCALE |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_top_idle: assert property (
    done && !pwrite && paddr == `A_TOP_OBJ &&
    $past(object_irq_status) == 6'h0 && $past(object_irq_status, 2) == 6'h0
    |-> prdata[7:4] == `NO_OBJECT) else $error("top field not all ones");
  a_irq_masked: assert property (
    (object_irq_status & ~$past(irq_enable)) == 6'h0)
    else $error("masked object raised irq");
  a_use_rise: assert property (
    (object_in_use & ~$past(object_in_use)) != 6'h0 |-> $past(done && pwrite))
    else $error("object enabled without write");
  a_use_fall: assert property (
    ($past(object_in_use) & ~object_in_use) != 6'h0 |-> $past(done && pwrite
    || bit_tick && frame_field == `FLD_EOF && eof_n >= 3'h5))
    else $error("object released off completion");
  a_tx_in_use: assert property (
    tx_request && $stable(object_in_use) |-> object_in_use[tx_select])
    else $error("request for idle object");
endmodule

bind can_mob_status_timer_regs can_regs_chk u_chk (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_enable(irq_enable), .object_in_use(object_in_use),
  .object_irq_status(object_irq_status), .bit_tick(bit_tick),
  .frame_field(frame_field), .tx_request(tx_request), .tx_select(tx_select));

// ---- test/can_node_model.sv ----
`timescale 1ns/1ns
`include "can_mob_defs.vh"
module can_node_model (
  // Clock and command
  input wire clk,
  input wire go,
  input wire [2:0] fault,
  // Bus side seen by the engine
  output reg bit_tick,
  output reg [3:0] frame_field,
  output reg rx_bit,
  output reg busy
);
  // Fixed frame: one data byte
  localparam [26:0] FRAME = {1'b0, 11'h2a5, 3'h0, 4'h1, 8'h5a};
  reg [14:0] crc;
  reg last;
  integer i;
  integer run;
  task put(input [3:0] fld, input b);
    begin
      @(posedge clk);
      bit_tick <= 1'b1;
      frame_field <= fld;
      rx_bit <= b;
      @(posedge clk);
      bit_tick <= 1'b0;
    end
  endtask
  // Stuffing keeps runs at five, so no stuff fault unless meant
  task stuffed(input [3:0] fld, input b);
    begin
      if (run == 5) begin
        put(fld, ~last);
        last = ~last;
        run = 1;
      end
      put(fld, b);
      run = (b == last) ? run + 1 : 1;
      last = b;
    end
  endtask
  initial begin
    bit_tick = 1'b0;
    frame_field = `FLD_IDLE;
    rx_bit = 1'b1;
    busy = 1'b0;
  end
  always begin
    @(posedge clk);
    if (go) begin
      busy <= 1'b1;
      crc = 15'h0;
      for (i = 26; i >= 0; i = i - 1)
        crc = {crc[13:0], 1'b0} ^ ((FRAME[i] ^ crc[14]) ? `CRC_POLY : 15'h0);
      crc[0] = crc[0] ^ fault[0];
      run = 0;
      last = 1'b1;
      for (i = 26; i >= 0; i = i - 1)
        stuffed(i == 26 ? `FLD_SOF : i > 13 ? `FLD_ARB : `FLD_CTRL, FRAME[i]);
      for (i = 14; i >= 0; i = i - 1)
        stuffed(`FLD_CRC, crc[i]);
      if (run == 5)
        put(`FLD_CRC, ~last);
      put(`FLD_CRC_DEL, ~fault[1]);
      put(`FLD_ACK, fault[2]);
      put(`FLD_ACK_DEL, 1'b1);
      // A faulted frame stops after the ack delimiter, with no EOF bits sent
      if (fault == 3'h0)
        for (i = 0; i < 7; i = i + 1)
          put(`FLD_EOF, 1'b1);
      frame_field <= `FLD_IDLE;
      busy <= 1'b0;
    end
  end
endmodule

// ---- test/can_mob_status_timer_regs_tb_top.sv ----
`timescale 1ns/1ns
`include "can_mob_defs.vh"
module can_mob_status_timer_regs_tb_top;
  reg clk, rst_b, psel, penable, pwrite, controller_enable, transmitting, go;
  reg [7:0] paddr, ad;
  reg [31:0] pwdata, rd, a;
  reg [5:0] irq_enable, rx_match;
  reg [3:0] rx_length;
  reg [2:0] fault;
  reg err, flip;
  wire [31:0] prdata;
  wire pready, pslverr, bit_tick, rx_bit, busy, tx_request;
  wire [5:0] object_in_use, object_irq_status;
  wire [3:0] frame_field, tx_length;
  wire [2:0] tx_select;
  integer miscompares, check_count, cyc, t0, n;
  can_mob_status_timer_regs dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .controller_enable(controller_enable), .irq_enable(irq_enable),
    .object_in_use(object_in_use), .object_irq_status(object_irq_status),
    .bit_tick(bit_tick), .rx_bit(rx_bit), .tx_bit(rx_bit ^ flip),
    .transmitting(transmitting), .frame_field(frame_field),
    .rx_match(rx_match), .rx_length(rx_length), .rx_data(64'h5a),
    .tx_request(tx_request), .tx_select(tx_select), .tx_length(tx_length));
  can_node_model u_node (.clk(clk), .go(go), .fault(fault),
    .bit_tick(bit_tick), .frame_field(frame_field), .rx_bit(rx_bit),
    .busy(busy));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= rst_b ? cyc + 1 : 0;
  // ****
  // Tasks
  // ****
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Request held until pready is sampled, then one idle edge
  task apb(input w, input [7:0] ad, input [31:0] wd);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 20) begin
        miscompares = miscompares + 1;
        stop_test;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rc(input string nm, input [7:0] ad, input [7:0] e);
    begin
      apb(1'b0, ad, 32'h0);
      chk(nm, {24'h0, e}, rd);
    end
  endtask
  task await(input want, input integer lim);
    begin
      n = 0;
      while (busy !== want && n < lim) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == lim) begin
        miscompares = miscompares + 1;
        stop_test;
      end
    end
  endtask
  task frame(input [2:0] f);
    begin
      fault <= f;
      go <= 1'b1;
      await(1'b1, 10);
      go <= 1'b0;
      await(1'b0, 600);
      repeat (3) @(posedge clk);
    end
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = 0;
    {controller_enable, transmitting, go, fault, rx_match, rx_length} = 0;
    flip = 1'b0;
    irq_enable = 6'h02;
    {miscompares, check_count} = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b1, `A_TIMER_LO, 32'hff);
    for (ad = 8'h0; ad < 8'h20; ad = ad + 8'h4)
      rc("reset", ad, ad == `A_TOP_OBJ ? `TOP_OBJ_RESET : 8'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test reset done");
    apb(1'b1, `A_TOP_OBJ, 32'h0a);
    rc("top spare", `A_TOP_OBJ, 8'hfa);
    apb(1'b1, `A_PAGE, 32'h60);
    apb(1'b1, `A_STATUS, 32'h11);
    rc("object six", `A_STATUS, 8'h0);
    apb(1'b1, `A_PAGE, 32'h20);
    apb(1'b1, `A_DATA, 32'h11);
    apb(1'b1, `A_DATA, 32'h22);
    rc("index step", `A_PAGE, 8'h22);
    apb(1'b1, `A_PAGE, 32'h29);
    rc("byte one", `A_DATA, 8'h22);
    rc("index held", `A_PAGE, 8'h29);
    $display("test page done");
    apb(1'b1, `A_PRESCALE, 32'h03);
    controller_enable <= 1'b1;
    repeat (40) @(posedge clk);
    t0 = cyc;
    apb(1'b0, `A_TIMER_LO, 32'h0);
    a = rd;
    while (cyc < t0 + 320) @(posedge clk);
    apb(1'b0, `A_TIMER_LO, 32'h0);
    chk("timer rate", 32'h0a, (rd - a) & 32'hff);
    $display("test timer done");
    for (ad = 8'h10; ad < 8'h30; ad = ad + 8'h10) begin
      apb(1'b1, `A_PAGE, {24'h0, ad});
      apb(1'b1, `A_STATUS, 32'h0);
      apb(1'b1, `A_CONTROL, ad[5] ? 32'hc1 : 32'h81);
    end
    rx_match <= 6'h06;
    rx_length <= 4'h2;
    frame(3'h0);
    apb(1'b1, `A_PAGE, 32'h10);
    rc("rx status", `A_STATUS, 8'ha0);
    rc("rx length", `A_CONTROL, 8'h82);
    rc("rx data", `A_DATA, 8'h5a);
    chk("in use", 32'h04, {26'h0, object_in_use});
    chk("irq status", 32'h02, {26'h0, object_irq_status});
    rc("top object", `A_TOP_OBJ, 8'h1a);
    rc("rx faults", `A_RX_FAULT, 8'h0);
    $display("test receive done");
    rx_match <= 6'h0;
    apb(1'b1, `A_PAGE, 32'h30);
    apb(1'b1, `A_STATUS, 32'h0);
    apb(1'b1, `A_CONTROL, 32'h43);
    apb(1'b1, `A_PAGE, 32'h00);
    apb(1'b1, `A_STATUS, 32'h0);
    apb(1'b1, `A_CONTROL, 32'h41);
    repeat (3) @(posedge clk);
    chk("tx pick", 32'h81, {tx_request, tx_select, tx_length});
    transmitting <= 1'b1;
    frame(3'h0);
    rc("tx status", `A_STATUS, 8'h40);
    apb(1'b1, `A_STATUS, 32'h0);
    rc("tx locked", `A_STATUS, 8'h40);
    apb(1'b1, `A_CONTROL, 32'h01);
    apb(1'b1, `A_STATUS, 32'h0);
    rc("tx cleared", `A_STATUS, 8'h0);
    chk("tx next", 32'hb3, {tx_request, tx_select, tx_length});
    frame(3'h4);
    rc("tx faults", `A_TX_FAULT, 8'h08);
    apb(1'b1, `A_PAGE, 32'h30);
    rc("ack flag", `A_STATUS, 8'h01);
    $display("test transmit done");
    transmitting <= 1'b0;
    rx_match <= 6'h04;
    frame(3'h1);
    rc("crc fault", `A_RX_FAULT, 8'h01);
    frame(3'h2);
    rc("form fault", `A_RX_FAULT, 8'h02);
    // Sent level inverted on every bit: the counter must saturate
    transmitting <= 1'b1;
    flip <= 1'b1;
    frame(3'h4);
    flip <= 1'b0;
    rc("bit fault", `A_STATUS, 8'h11);
    rc("tx saturate", `A_TX_FAULT, `FAULT_MAX);
    $display("test faults done");
    stop_test;
  end
endmodule
